/* File: rtl/lcd_host_port.sv */
// pin logic of a bitmap lcd driver: host port, line latch, drive levels
// assumes one clock, all pins asynchronous, ram and decoder outside
//
// Behaviour
// R01 - chip select low enables every bus access
// R02 - line latch rise latches pixels, counts line
// R03 - motorola mode: strobe is active-high enable
// R04 - intel mode: low strobe reads, drives bus
// R05 - motorola mode: direction high reads, low writes
// R06 - intel mode: write captured on rising edge
// R07 - select line routes byte as data/instruction
// R08 - data bus released unless device reads out
// R09 - alternation output as master, input as slave
// R10 - row level from alternation and row select
// R11 - column level from alternation and pixel
// R12 - reset pin edge resets, level picks mode
// R13 - slave scans rows in reverse order
// R14 - select high is data, low instruction
// R15 - host holds controls stable during enable
`include "lcd_host_port_cfg.svh"
module lcd_host_port
    import lcd_host_port_pkg::*;
#(
    parameter int ROWS = 16,               // row outputs
    parameter int COLS = 61                // column outputs
) (
    input  wire logic              i_mclk,
    input  wire logic              i_resetn,
    input  wire logic              i_ce,
    input  wire logic              i_chip_select_n,
    input  wire logic              i_host_strobe,
    input  wire logic              i_transfer_direction,
    input  wire logic              i_data_or_command_select,
    input  wire logic [7:0]        i_host_data,
    output logic      [7:0]        o_host_data,
    output logic                   o_host_data_oe,
    input  wire logic              i_line_latch_strobe,
    input  wire logic              i_reset_pin,
    input  wire logic              i_role_select,
    input  wire logic              i_frame_alternation,
    output logic                   o_frame_alternation,
    output logic                   o_frame_alternation_oe,
    input  wire logic [7:0]        i_read_data,
    input  wire logic [COLS-1:0]   i_line_pixels,
    output logic                   o_read_start,
    output logic                   o_data_wr,
    output logic                   o_cmd_wr,
    output logic      [7:0]        o_wr_byte,
    output logic                   o_pin_reset,
    output logic                   o_bus_mode_moto,
    output logic      [3*ROWS-1:0] o_row_drive_outputs,
    output logic      [3*COLS-1:0] o_column_drive_outputs
);
    localparam int LW = $clog2(ROWS);      // line counter width

    // all state of the block
    typedef struct packed {
        logic [`PIN_WIDTH-1:0] s1;         // first sync stage
        logic [`PIN_WIDTH-1:0] s2;         // second sync stage
        logic                  strobe_q;   // strobe, one cycle late
        logic                  dir_q;      // intel write strobe, late
        logic [1:0]            fill;       // sync pipeline filled
        logic                  lls_q;      // line latch, one cycle late
        logic                  rst_q;      // reset pin, one cycle late
        logic                  fr_q;       // slave alternation, late
        logic                  primed;     // mode strap caught
        bus_mode_e             mode;       // host bus type
        logic                  drv;        // device drives data bus
        logic [7:0]            rd_byte;    // byte being read out
        logic                  rd_start;   // read began
        logic                  data_wr;    // display data written
        logic                  cmd_wr;     // instruction written
        logic [7:0]            wr_byte;    // captured byte
        logic                  pin_rst;    // reset pin edge seen
        logic [LW-1:0]         line;       // line counter
        logic                  fr;         // master alternation
        logic [COLS-1:0]       pix;        // latched line of pixels
    } state_s;

    state_s r;                             // registered state
    state_s n;                             // next state

    // synchronised views of the pins
    logic          cs_n;
    logic          stb;
    logic          dir;
    logic          dcs;
    logic          lls;
    logic          rstp;
    logic          frin;
    logic          master;
    logic [7:0]    bus;
    logic          drv_c;                  // read drive wanted now
    logic          wr_c;                   // write strobe completes
    logic          fr_now;                 // alternation in use

    assign cs_n   = r.s2[`PIN_CS_N];
    assign stb    = r.s2[`PIN_STROBE];
    assign dir    = r.s2[`PIN_DIR];
    assign dcs    = r.s2[`PIN_DCS];
    assign lls    = r.s2[`PIN_LLS];
    assign rstp   = r.s2[`PIN_RST];
    assign frin   = r.s2[`PIN_FR];
    assign master = r.s2[`PIN_ROLE];
    assign bus    = r.s2[`PIN_DATA_LO +: 8];
    // slave follows the master's alternation, master makes its own
    assign fr_now = master ? r.fr : frin;  // [R09]

    // next state; pins pass two flops before anything reads them
    always_comb begin
        n          = r;
        n.s1       = {i_host_data, i_role_select, i_frame_alternation,
                      i_reset_pin, i_line_latch_strobe,
                      i_data_or_command_select, i_transfer_direction,
                      i_host_strobe, i_chip_select_n};
        n.s2       = r.s1;
        n.strobe_q = stb;
        n.dir_q    = dir;
        // two ones mark that stage 2 holds real pin levels
        n.fill     = {r.fill[0], 1'b1};
        n.lls_q    = lls;
        n.rst_q    = rstp;
        n.fr_q     = frin;
        n.rd_start = 1'b0;
        n.data_wr  = 1'b0;
        n.cmd_wr   = 1'b0;
        n.pin_rst  = 1'b0;
        // read drive and write completion per bus type
        if (r.mode == bus_moto) begin
            drv_c = !cs_n && stb && dir;               // [R01] [R03] [R05]
            // 68 style bus latches write data as enable falls
            wr_c  = !cs_n && !stb && r.strobe_q && !dir; // [R05] [R15]
        end else begin
            drv_c = !cs_n && !stb;                     // [R01] [R04]
            // the write strobe is the direction pin in this bus type
            wr_c  = !cs_n && dir && !r.dir_q;          // [R06]
        end
        // edge detectors hold reset zeros until the pipeline fills;
        // a zero chip select there would look like a read, so nothing
        // on the bus counts before the strap has been caught
        if (!r.primed) begin
            drv_c = 1'b0;
            wr_c  = 1'b0;
        end
        // bus is driven only during a read, released otherwise
        n.drv = drv_c;                                 // [R08]
        if (drv_c && !r.drv) begin
            n.rd_byte  = i_read_data;                  // [R04]
            n.rd_start = 1'b1;
        end
        // route the byte by the select line, high meaning data
        if (wr_c) begin
            n.wr_byte = bus;                           // [R06]
            n.data_wr = dcs;                           // [R07] [R14]
            n.cmd_wr  = !dcs;                          // [R07] [R14]
        end
        // line latch rise: take one line and step the counter
        if (r.primed && lls && !r.lls_q) begin
            n.pix  = i_line_pixels;                    // [R02]
            n.line = r.line + 1'b1;                    // [R02]
            if (r.line == LW'(ROWS - 1)) begin
                n.line = `RST_LINE;
                n.fr   = !r.fr;    // one toggle per frame, 50 percent
            end
        end
        // a slave restarts its scan whenever alternation turns
        if (r.primed && !master && (frin != r.fr_q)) begin
            n.line = `RST_LINE;                        // [R09]
        end
        // strap is caught once after release, since the async reset
        // may only load constants
        if (!r.primed) begin
            // wait until the strap level really stands in the second
            // stage; reading it earlier would see the reset zero and
            // fake a reset-pin edge one cycle later
            if (r.fill[1]) begin
                n.primed = 1'b1;
                n.mode   = rstp ? bus_moto : bus_intel; // [R12]
            end
        end else if (rstp != r.rst_q) begin
            // any edge resets; the level left behind picks the bus
            n.mode    = rstp ? bus_moto : bus_intel;   // [R12]
            n.pin_rst = 1'b1;
            n.line    = `RST_LINE;
            n.fr      = 1'b0;
            n.pix     = '0;
            n.drv     = 1'b0;
            n.data_wr = 1'b0;
            n.cmd_wr  = 1'b0;
        end
    end

    // one register for everything; clock enable freezes it all
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            r <= '0;
        end else if (i_ce) begin
            r <= n;
        end
    end

    // port outputs taken straight from state
    assign o_host_data            = r.rd_byte;
    assign o_host_data_oe         = r.drv;
    assign o_frame_alternation    = r.fr;
    assign o_frame_alternation_oe = master;            // [R09]
    assign o_read_start           = r.rd_start;
    assign o_data_wr              = r.data_wr;
    assign o_cmd_wr               = r.cmd_wr;
    assign o_wr_byte              = r.wr_byte;
    assign o_pin_reset            = r.pin_rst;
    assign o_bus_mode_moto        = (r.mode == bus_moto);

    // row levels; a slave counts the same line but from the far end,
    // so its outputs stand for the upper half of the panel
    genvar gi;
    generate
        for (gi = 0; gi < ROWS; gi++) begin : g_row
            logic sel;
            assign sel = master ? (r.line == LW'(gi))
                                : (r.line == LW'(ROWS - 1 - gi)); // [R13]
            assign o_row_drive_outputs[3*gi +: 3] =
                fr_now ? (sel ? `LVL_V5 : `LVL_V1)
                       : (sel ? `LVL_VDD : `LVL_V4);            // [R10]
        end
        // column levels from the latched pixel of the line
        for (gi = 0; gi < COLS; gi++) begin : g_col
            assign o_column_drive_outputs[3*gi +: 3] =
                fr_now ? (r.pix[gi] ? `LVL_VDD : `LVL_V2)
                       : (r.pix[gi] ? `LVL_V5 : `LVL_V3);       // [R11]
        end
    endgenerate

    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    sequence s_intel_wr;
        r.primed && r.mode == bus_intel && !cs_n && dir && !r.dir_q
            && rstp == r.rst_q && i_ce;
    endsequence
    sequence s_moto_rd;
        r.primed && r.mode == bus_moto && !cs_n && stb && dir && !r.drv
            && rstp == r.rst_q && i_ce;
    endsequence

    cs_blocks_bus_a: assert property (                 // [R01]
        cs_n && i_ce |=> !o_data_wr && !o_cmd_wr && !o_host_data_oe)
        else $error("access taken while chip select high");
    intel_write_a: assert property (                   // [R06]
        s_intel_wr |=> (o_data_wr ^ o_cmd_wr) && o_wr_byte == $past(bus))
        else $error("intel write not captured on rising edge");
    route_select_a: assert property (                  // [R07]
        s_intel_wr |=> o_data_wr == $past(dcs))
        else $error("byte routed by wrong select level");
    moto_read_a: assert property (                     // [R05]
        s_moto_rd |=> o_read_start && o_host_data_oe
            && o_host_data == $past(i_read_data))
        else $error("motorola read did not start");
    // a 68 style write lands as the enable falls, not as it rises
    sequence s_moto_wr;
        r.primed && r.mode == bus_moto && !cs_n && !stb && r.strobe_q
            && !dir && rstp == r.rst_q && i_ce;
    endsequence
    moto_write_a: assert property (                    // [R03]
        s_moto_wr |=> (o_data_wr ^ o_cmd_wr) && o_wr_byte == $past(bus))
        else $error("motorola write not captured as enable fell");
    // before the strap is caught the port must stay silent
    startup_quiet_a: assert property (                 // [R08]
        !r.primed |=> !o_read_start && !o_data_wr && !o_cmd_wr
            && !o_host_data_oe)
        else $error("bus activity before the mode strap settled");
    intel_release_a: assert property (                 // [R04]
        r.mode == bus_intel && stb && i_ce && rstp == r.rst_q
            |=> !o_host_data_oe)
        else $error("bus driven while read strobe high");
    line_step_a: assert property (                     // [R02]
        master && lls && !r.lls_q && r.line != LW'(ROWS - 1)
            && r.primed && rstp == r.rst_q && i_ce
            |=> r.line == $past(r.line) + 1'b1)
        else $error("line counter did not advance");
    reset_mode_a: assert property (                    // [R12]
        r.primed && rstp && !r.rst_q && i_ce
            |=> o_pin_reset && o_bus_mode_moto ##1 !o_pin_reset)
        else $error("rising reset edge did not pick motorola");
    fr_dir_a: assert property (                        // [R09]
        o_frame_alternation_oe == master)
        else $error("alternation direction wrong for role");
    row_level_a: assert property (                     // [R10]
        master && r.line == '0 |-> o_row_drive_outputs[2:0]
            == (fr_now ? `LVL_V5 : `LVL_VDD))
        else $error("selected row level wrong");
    slave_order_a: assert property (                   // [R13]
        !master && r.line == '0 && !fr_now
            |-> o_row_drive_outputs[3*ROWS-1 -: 3] == `LVL_VDD)
        else $error("slave row order not reversed");
    col_level_a: assert property (                     // [R11]
        o_column_drive_outputs[2:0] == (fr_now
            ? (r.pix[0] ? `LVL_VDD : `LVL_V2)
            : (r.pix[0] ? `LVL_V5 : `LVL_V3)))
        else $error("column level wrong");
endmodule // lcd_host_port

/* File: include/lcd_host_port_cfg.svh */
// constants for the lcd driver host port and display pins
// assumes one 250 MHz clock domain and pins synchronised inside
`ifndef LCD_HOST_PORT_CFG_SVH
`define LCD_HOST_PORT_CFG_SVH
// positions inside the synchronised pin vector
`define PIN_CS_N      0
`define PIN_STROBE    1
`define PIN_DIR       2
`define PIN_DCS       3
`define PIN_LLS       4
`define PIN_RST       5
`define PIN_FR        6
`define PIN_ROLE      7
`define PIN_DATA_LO   8
`define PIN_WIDTH     16
// drive level codes on row and column outputs
`define LVL_VDD       3'h0
`define LVL_V1        3'h1
`define LVL_V2        3'h2
`define LVL_V3        3'h3
`define LVL_V4        3'h4
`define LVL_V5        3'h5
// reset values
`define RST_BYTE      8'h00
`define RST_LINE      4'h0
`endif

/* File: include/lcd_host_port_pkg.sv */
// types shared by the lcd driver host port
// assumes the cfg header supplies the level codes
package lcd_host_port_pkg;
    typedef logic [2:0] level_t;           // one drive level code
    typedef enum logic {
        bus_intel,                         // separate read/write strobes
        bus_moto                           // enable plus read/write
    } bus_mode_e;
endpackage

/* File: testbench/host_model.sv */
// host processor model driving the parallel port pins of the lcd driver
// assumes the bench resolves the data bus and tells it the bus mode
module host_model (
    input  wire logic       i_clk,
    input  wire logic       i_moto,
    output logic            o_cs_n,
    output logic            o_stb,
    output logic            o_dir,
    output logic            o_dcs,
    output logic [7:0]      o_dout
);
    timeunit 1ns;
    timeprecision 100ps;
    // pins idle: deselected, strobes inactive for intel mode
    initial begin
        o_cs_n = 1'b1;
        o_stb  = 1'b1;
        o_dir  = 1'b1;
        o_dcs  = 1'b0;
        o_dout = 8'h00;
    end
    // park the strobe at the inactive level of the current mode
    task automatic idle();
        o_stb = ~i_moto;
        o_dir = 1'b1;
    endtask
    // one transfer; each strobe level lasts 4 cycles so the sync sees it
    task automatic xfer(input logic rd, input logic a0,
                        input logic [7:0] d, input logic sel_n);
        @(negedge i_clk);
        o_cs_n = sel_n;
        o_dcs  = a0;
        o_dout = d;
        o_dir  = i_moto ? rd : 1'b1;
        @(negedge i_clk);
        if (i_moto) o_stb = 1'b1;
        else if (rd) o_stb = 1'b0;
        else o_dir = 1'b0;
        repeat (4) @(negedge i_clk);
        // only the strobe moves here; controls stay put
        if (i_moto) o_stb = 1'b0;
        else o_stb = 1'b1;
        if (!i_moto) o_dir = 1'b1;
        repeat (4) @(negedge i_clk);
        o_cs_n = 1'b1;
        o_dir  = 1'b1;
        o_dout = ~d; // released bus must not keep the old byte
    endtask
endmodule // host_model

/* File: testbench/tb.sv */
// self-checking bench: host bus in both modes, line latch, drive levels
// assumes the design's assertions sit inside it; no separate checker
`include "lcd_host_port_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rstn, ce, rst_pin, role, fr_in, lls, moto;
    logic [7:0]   rd_data, rd_out, wr_byte, bus, h_dout, seen, tmp;
    logic [7:0]   n_dw, n_cw, n_rs, n_pr, n_oe, dw, cw, rs, p0, m0, d;
    logic         oe, fr_out, fr_oe, rd_st, data_wr, cmd_wr, pin_rst;
    logic         mode_moto, cs_n, stb, dir, dcs, a, f0;
    logic [63:0]  px;
    logic [47:0]  rows;
    logic [182:0] cols;
    logic [15:0]  lfsr_q = 16'h002f;   // fixed seed keeps runs repeatable
    int fail_count = 0;
    int checks_done = 0;
    // device wins the bus while it drives, otherwise the host's lines
    assign bus = oe ? rd_out : h_dout;
    always #2 clk = ~clk;
    host_model h (.i_clk(clk), .i_moto(moto), .o_cs_n(cs_n), .o_stb(stb),
        .o_dir(dir), .o_dcs(dcs), .o_dout(h_dout));
    lcd_host_port DUT (.i_mclk(clk), .i_resetn(rstn), .i_ce(ce),
        .i_chip_select_n(cs_n), .i_host_strobe(stb),
        .i_transfer_direction(dir), .i_data_or_command_select(dcs),
        .i_host_data(bus), .o_host_data(rd_out), .o_host_data_oe(oe),
        .i_line_latch_strobe(lls), .i_reset_pin(rst_pin),
        .i_role_select(role), .i_frame_alternation(fr_in),
        .o_frame_alternation(fr_out), .o_frame_alternation_oe(fr_oe),
        .i_read_data(rd_data), .i_line_pixels(px[60:0]),
        .o_read_start(rd_st), .o_data_wr(data_wr), .o_cmd_wr(cmd_wr),
        .o_wr_byte(wr_byte), .o_pin_reset(pin_rst),
        .o_bus_mode_moto(mode_moto), .o_row_drive_outputs(rows),
        .o_column_drive_outputs(cols));
    // count one-cycle pulses and catch the byte the device puts out
    always @(posedge clk) begin
        n_dw <= n_dw + {7'h00, data_wr};
        n_cw <= n_cw + {7'h00, cmd_wr};
        n_rs <= n_rs + {7'h00, rd_st};
        n_pr <= n_pr + {7'h00, pin_rst};
        n_oe <= n_oe + {7'h00, oe};
        if (oe) seen <= bus;
    end
    // sixteen-bit shift register, the only source of random values
    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12]
                  ^ lfsr_q[10]};
        return lfsr_q;
    endfunction
    function automatic logic [2:0] row_lvl(input logic f, input logic s);
        if (f) return s ? `LVL_V5 : `LVL_V1;
        return s ? `LVL_VDD : `LVL_V4;
    endfunction
    function automatic logic [2:0] col_lvl(input logic f, input logic p);
        if (f) return p ? `LVL_VDD : `LVL_V2;
        return p ? `LVL_V5 : `LVL_V3;
    endfunction
    // index of the single selected row, 8'hee if the pattern is wrong
    function automatic logic [7:0] sel_row(input logic f);
        logic [7:0] idx;
        int n;
        idx = 8'h00;
        n = 0;
        for (int k = 0; k < 16; k++) begin
            if (rows[3*k+:3] === row_lvl(f, 1'b1)) begin
                idx = 8'(k);
                n++;
            end else if (rows[3*k+:3] !== row_lvl(f, 1'b0)) n += 2;
        end
        return (n == 1) ? idx : 8'hee;
    endfunction
    // number of columns whose level disagrees with the latched pixel
    function automatic logic [7:0] col_bad(input logic f);
        logic [7:0] n;
        n = 8'h00;
        for (int k = 0; k < 61; k++)
            if (cols[3*k+:3] !== col_lvl(f, px[k])) n++;
        return n;
    endfunction
    task automatic chk(input string nm, input logic [7:0] exp,
                       input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // edge on the reset pin; its new level is the bus mode
    task automatic strap(input logic v);
        p0 = n_pr;
        @(negedge clk);
        rst_pin = v;
        moto = v;
        h.idle();
        repeat (6) @(negedge clk);
        chk("pin_reset", p0 + 8'h01, n_pr);
        chk("mode", {7'h00, v}, {7'h00, mode_moto});
    endtask
    // fresh random pixels, then one latch pulse of 4 high, 4 low cycles
    task automatic latch();
        for (int b = 0; b < 64; b += 16) begin
            px[b+:16] = rnd();
        end
        @(negedge clk);
        lls = 1'b1;
        repeat (4) @(negedge clk);
        lls = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // watchdog: a hang counts as a mismatch
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
    initial begin
        {clk, rstn, rst_pin, role, fr_in, lls, moto} = 7'b0001000;
        {ce, rd_data, px} = {1'b1, 8'h00, 64'h0000_0000_0000_0000};
        {n_dw, n_cw, n_rs, n_pr, n_oe, seen} = 48'h0000_0000_0000;
        repeat (4) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        repeat (6) @(negedge clk);
        chk("mode", 8'h00, {7'h00, mode_moto});
        // intel mode first, then motorola after a rising reset-pin edge
        for (int m = 0; m < 2; m++) begin
            if (m == 1) strap(1'b1);
            for (int i = 0; i < 6; i++) begin
                tmp = 8'(rnd());
                d = (i == 0) ? 8'hff : tmp; // all-ones byte as a corner
                a = tmp[i%8];
                {dw, cw} = {n_dw, n_cw};
                h.xfer(1'b0, a, d, 1'b0);
                chk("data_wr", dw + {7'h00, a}, n_dw);
                chk("cmd_wr", cw + {7'h00, ~a}, n_cw);
                chk("wr_byte", d, wr_byte);
                rd_data = ~d;
                rs = n_rs;
                h.xfer(1'b1, a, 8'h00, 1'b0);
                chk("read_start", rs + 8'h01, n_rs);
                chk("read_byte", ~d, seen);
                chk("bus_oe", 8'h00, {7'h00, oe});
            end
            // deselected cycles must leave no trace at all
            p0 = n_rs + n_dw + n_cw + n_oe;
            h.xfer(1'b0, 1'b1, 8'h5a, 1'b1);
            h.xfer(1'b1, 1'b1, 8'h00, 1'b1);
            chk("deselect", p0, n_rs + n_dw + n_cw + n_oe);
            $display("test bus mode %0d done", m);
        end
        // master: line steps on each latch, alternation flips at wrap
        chk("fr_oe", 8'h01, {7'h00, fr_oe});
        m0 = sel_row(fr_out);
        f0 = fr_out;
        for (int k = 0; k < 16; k++) begin
            latch();
            chk("columns", 8'h00, col_bad(fr_out));
            chk("row_sel", 8'(k + 1) % 8'h10 + m0 - m0 % 8'h10,
                sel_row(fr_out));
            if (k < 15) chk("fr_hold", {7'h00, f0}, {7'h00, fr_out});
        end
        chk("fr_wrap", {7'h00, ~f0}, {7'h00, fr_out});
        // a latch pulse while the clock enable is low must be missed
        @(negedge clk) {ce, lls} = 2'b01;
        repeat (4) @(negedge clk);
        lls = 1'b0;
        repeat (4) @(negedge clk);
        ce = 1'b1;
        repeat (6) @(negedge clk);
        chk("ce_freeze", 8'h00, sel_row(fr_out));
        $display("test master display done");
        // slave: alternation from outside, rows scanned in reverse
        @(negedge clk) role = 1'b0;
        repeat (6) @(negedge clk);
        chk("fr_oe", 8'h00, {7'h00, fr_oe});
        fr_in = 1'b1;
        repeat (6) @(negedge clk);
        chk("slave_row", 8'h0f - m0, sel_row(1'b1));
        chk("slave_cols", 8'h00, col_bad(1'b1));
        strap(1'b0);
        $display("test slave display done");
        close_out();
    end
endmodule // tb
